// file: bench/crs_cpu_regs_properties.sv
// port checks of the cpu register set
`timescale 1ns/100ps
`default_nettype none
module crs_cpu_regs_properties (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic [7:0] I_DATA,
    input wire logic I_ACC_WE,
    input wire logic I_ALU_EN,
    input wire crs_pkg::crs_alu_s I_ALU,
    input wire crs_pkg::crs_ops_s I_OPS,
    input wire logic I_SEQ_GO,
    input wire crs_pkg::crs_seq_e I_SEQ_KIND,
    input wire logic [7:0] O_ACC,
    input wire logic [15:0] O_IP,
    input wire logic [7:0] O_CC,
    input wire logic [15:0] O_SP,
    input wire crs_pkg::crs_stk_s O_STK,
    input wire logic O_BUSY,
    input wire logic O_IRQ_READY
);
    import crs_pkg::*;
    logic go_q;
    // go seen at the last edge
    always_ff @(posedge I_CLK) begin
        go_q <= I_SEQ_GO & ~I_SYS_RST;
    end
    // nothing running or just asked for
    wire idle = !O_BUSY && !go_q;
    wire start = I_SEQ_GO && idle;
    wire quiet = idle && !I_SEQ_GO;

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_SYS_RST);

    AST_RESET_STATE: assert property (
        $fell(I_SYS_RST) |-> O_SP == CRS_SP_RESET && O_CC == CRS_CC_RESET)
        else $error("bad reset state");
    AST_CC_FIXED: assert property (
        O_CC[7:5] == 3'b111) else $error("fixed flags not one");
    AST_SP_WINDOW: assert property (
        O_SP[15:6] == 10'h003) else $error("pointer out of window");
    AST_ACC_LOAD: assert property (
        I_ACC_WE && quiet |=> O_ACC == $past(I_DATA))
        else $error("acc write lost");
    AST_ZERO_NEG: assert property (
        I_ALU_EN && quiet && I_ALU.upd_z && I_ALU.upd_n |=>
        O_CC[CRS_CC_Z] == ($past(I_ALU.res) == 8'h00) &&
        O_CC[CRS_CC_N] == $past(I_ALU.res[7]))
        else $error("z or n flag wrong");
    AST_CARRY_SET: assert property (
        I_OPS.set_carry_op && quiet |=> O_CC[CRS_CC_C])
        else $error("set carry ignored");
    AST_INT_ENTRY: assert property (
        start && I_SEQ_KIND == SEQ_INT |=> O_CC[CRS_CC_I] ##1 O_STK.we &&
        O_STK.addr == $past(O_SP, 2) && O_STK.wdata == $past(O_IP[7:0], 2))
        else $error("bad entry");
    AST_INT_FIVE: assert property (
        start && I_SEQ_KIND == SEQ_INT |=> ##1 O_STK.we [*5] ##1 !O_STK.we)
        else $error("entry not five bytes");
    AST_CALL_TWO: assert property (
        start && I_SEQ_KIND == SEQ_CALL |=> ##1 O_STK.we [*2] ##1 !O_STK.we)
        else $error("call not two bytes");
    AST_PUSH_DOWN: assert property (
        O_STK.we && $past(O_STK.we) |->
        O_STK.addr[5:0] == $past(O_STK.addr[5:0]) - 6'h01)
        else $error("push not descending");
    AST_POP_UP: assert property (
        O_STK.re && $past(O_STK.re) |->
        O_STK.addr[5:0] == $past(O_STK.addr[5:0]) + 6'h01)
        else $error("pop not ascending");
    AST_INTERRUPT_RETURN_OP_UNMASK: assert property (
        start && I_SEQ_KIND == SEQ_INTERRUPT_RETURN_OP |-> ##7 !O_CC[CRS_CC_I])
        else $error("return left mask set");
    AST_IRQ_READY: assert property (
        O_IRQ_READY |-> !$past(O_CC[CRS_CC_I]) && !$past(O_BUSY))
        else $error("served while masked or busy");
endmodule
bind crs_cpu_regs crs_cpu_regs_properties u_crs_cpu_regs_properties (
    .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_DATA(I_DATA),
    .I_ACC_WE(I_ACC_WE), .I_ALU_EN(I_ALU_EN), .I_ALU(I_ALU), .I_OPS(I_OPS),
    .I_SEQ_GO(I_SEQ_GO), .I_SEQ_KIND(I_SEQ_KIND), .O_ACC(O_ACC),
    .O_IP(O_IP), .O_CC(O_CC), .O_SP(O_SP), .O_STK(O_STK),
    .O_BUSY(O_BUSY), .O_IRQ_READY(O_IRQ_READY)
);
`default_nettype wire

// file: bench/crs_stack_mem.sv
// behavioural stack ram behind the stack port
`timescale 1ns/100ps
`default_nettype none
module crs_stack_mem (
    input wire logic i_clk,
    input wire crs_pkg::crs_stk_s i_stk,
    output logic [7:0] o_rdata
);
    import crs_pkg::*;
    logic [7:0] mem_reg [0:63];
    logic [7:0] last_reg = 8'h00;
    // writes land at the edge ending the push cycle
    always_ff @(posedge i_clk) begin
        if (i_stk.we) begin
            mem_reg[i_stk.addr[5:0]] <= i_stk.wdata;
        end
        if (i_stk.re) begin
            last_reg <= mem_reg[i_stk.addr[5:0]];
        end
    end
    // idle bus shows the inverse of the last byte
    assign o_rdata = i_stk.re ? mem_reg[i_stk.addr[5:0]] : ~last_reg;
endmodule
`default_nettype wire

// file: bench/testbench.sv
// self-checking bench for the cpu register set
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import crs_pkg::*;
    logic I_CLK, I_SYS_RST, I_ACC_WE, I_X_WE, I_Y_WE, I_SP_WE, I_SP_REINIT;
    logic I_IP_WE, I_IP_INC, I_ALU_EN, I_SEQ_GO, I_TRAP, I_IRQ;
    logic O_BUSY, O_IRQ_READY;
    logic [7:0] I_DATA, I_STK_RDATA, O_ACC, O_IDX_X, O_IDX_Y, O_CC;
    logic [15:0] I_IP_D, O_IP, O_SP;
    crs_alu_s I_ALU;
    crs_ops_s I_OPS;
    crs_seq_e I_SEQ_KIND;
    crs_src_e I_PP_SEL;
    crs_stk_s O_STK;
    int failures = 0;
    int n_checks = 0;
    // row: select, data, alu outcome, expected flags
    typedef struct packed {
        logic [1:0] sel;
        logic [7:0] d;
        logic [7:0] res;
        logic c;
        logic h;
        logic [3:0] upd;
        logic [7:0] cc;
    } crs_row_s;
    crs_row_s rows [0:4] = '{'{2'h0, 8'h5a, 8'h00, 1'b1, 1'b1, 4'hf, 8'hfb},
        '{2'h1, 8'ha5, 8'h80, 1'b0, 1'b0, 4'hf, 8'hec},
        '{2'h2, 8'h3c, 8'h7f, 1'b1, 1'b1, 4'h4, 8'he8},
        '{2'h3, 8'h05, 8'h00, 1'b1, 1'b1, 4'h3, 8'heb},
        '{2'h3, 8'hc2, 8'h01, 1'b0, 1'b1, 4'h8, 8'hfb}};
    // clear carry, set carry, unmask, mask
    crs_ops_s ops_tab [0:3] = '{4'b0100, 4'b1000, 4'b0001, 4'b0010};
    logic [7:0] cc_tab [0:3] = '{8'hfa, 8'hfb, 8'hf3, 8'hfb};
    // entry bytes at 02h downwards
    logic [7:0] push_tab [0:3] = '{8'h34, 8'h12, 8'ha5, 8'h5a};

    crs_cpu_regs u_crs_cpu_regs (
        .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_DATA(I_DATA),
        .I_ACC_WE(I_ACC_WE), .I_X_WE(I_X_WE), .I_Y_WE(I_Y_WE),
        .I_SP_WE(I_SP_WE), .I_SP_REINIT(I_SP_REINIT), .I_IP_WE(I_IP_WE),
        .I_IP_INC(I_IP_INC), .I_IP_D(I_IP_D), .I_ALU_EN(I_ALU_EN),
        .I_ALU(I_ALU), .I_OPS(I_OPS), .I_SEQ_GO(I_SEQ_GO),
        .I_SEQ_KIND(I_SEQ_KIND), .I_PP_SEL(I_PP_SEL), .I_TRAP(I_TRAP),
        .I_IRQ(I_IRQ), .I_STK_RDATA(I_STK_RDATA), .O_ACC(O_ACC),
        .O_IDX_X(O_IDX_X), .O_IDX_Y(O_IDX_Y), .O_IP(O_IP), .O_CC(O_CC),
        .O_SP(O_SP), .O_STK(O_STK), .O_BUSY(O_BUSY),
        .O_IRQ_READY(O_IRQ_READY)
    );
    crs_stack_mem u_crs_stack_mem (
        .i_clk(I_CLK), .i_stk(O_STK), .o_rdata(I_STK_RDATA)
    );

    // 10 mhz clock
    initial begin
        I_CLK = 1'b0;
        forever begin
            #50 I_CLK = ~I_CLK;
        end
    end

    // n edges, then settle
    task automatic tick(input int n = 1);
        repeat (n) @(posedge I_CLK);
        #10;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: byte %h not %h", $time, got, exp);
        end
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: word %h not %h", $time, got, exp);
        end
    endtask
    task automatic pulse_ops(input crs_ops_s o);
        I_OPS = o;
        tick();
        I_OPS = '0;
        tick();
    endtask
    // one sequence; a write during it is refused
    task automatic run_seq(input crs_seq_e k, input crs_src_e s,
            input logic [15:0] tgt);
        I_SEQ_GO = 1'b1;
        I_SEQ_KIND = k;
        I_PP_SEL = s;
        I_IP_D = tgt;
        tick();
        I_SEQ_GO = 1'b0;
        I_ACC_WE = 1'b1;
        I_DATA = 8'h77;
        tick();
        I_ACC_WE = 1'b0;
        for (int n = 0; n < 20 && O_BUSY !== 1'b0; n++) begin
            tick();
        end
        tick();
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // cuts a hang short
    initial begin
        repeat (3000) @(posedge I_CLK);
        failures++;
        $display("unexpected at %0t: timeout", $time);
        tally_and_finish();
    end

    initial begin
        {I_SYS_RST, I_ACC_WE, I_X_WE, I_Y_WE, I_SP_WE, I_SP_REINIT} = 6'h20;
        {I_IP_WE, I_IP_INC, I_ALU_EN, I_SEQ_GO, I_TRAP, I_IRQ} = 6'h00;
        I_DATA = 8'h00;
        I_IP_D = 16'h0000;
        I_ALU = '0;
        I_OPS = '0;
        I_SEQ_KIND = SEQ_INT;
        I_PP_SEL = SRC_ACC;
        tick(3);
        chk16(O_SP, 16'h00ff);
        chk8(O_CC, 8'he8);
        I_SYS_RST = 1'b0;
        foreach (rows[i]) begin
            I_DATA = rows[i].d;
            {I_SP_WE, I_Y_WE, I_X_WE, I_ACC_WE} = 4'h1 << rows[i].sel;
            I_ALU = {rows[i].res, rows[i].c, rows[i].h, rows[i].upd};
            I_ALU_EN = 1'b1;
            tick();
            {I_SP_WE, I_Y_WE, I_X_WE, I_ACC_WE, I_ALU_EN} = 5'h00;
            chk8(O_CC, rows[i].cc);
            if (rows[i].sel == 2'h3) begin
                chk16(O_SP, {10'h003, rows[i].d[5:0]});
            end else begin
                chk8(rows[i].sel == 2'h0 ? O_ACC : rows[i].sel == 2'h1 ?
                    O_IDX_X : O_IDX_Y, rows[i].d);
            end
        end
        for (int k = 0; k < 4; k++) begin
            pulse_ops(ops_tab[k]);
            chk8(O_CC, cc_tab[k]);
        end
        // masked request waits for unmask
        I_IRQ = 1'b1;
        tick();
        I_IRQ = 1'b0;
        tick(2);
        chk8({7'h00, O_IRQ_READY}, 8'h00);
        pulse_ops(4'b0001);
        tick(2);
        chk8({7'h00, O_IRQ_READY}, 8'h01);
        I_IP_WE = 1'b1;
        I_IP_D = 16'h1234;
        tick();
        I_IP_WE = 1'b0;
        chk16(O_IP, 16'h1234);
        // entry from 00c2h wraps
        run_seq(SEQ_INT, SRC_ACC, 16'h8000);
        chk16(O_SP, 16'h00fd);
        chk16(O_IP, 16'h8000);
        chk8(O_ACC, 8'h5a);
        for (int k = 0; k < 4; k++) begin
            chk8(u_crs_stack_mem.mem_reg[6'(2 - k)], push_tab[k]);
        end
        {I_Y_WE, I_X_WE, I_ACC_WE} = 3'h7;
        I_DATA = 8'h00;
        tick();
        {I_Y_WE, I_X_WE, I_ACC_WE} = 3'h0;
        run_seq(SEQ_INTERRUPT_RETURN_OP, SRC_ACC, 16'h0000);
        chk16(O_SP, 16'h00c2);
        chk16(O_IP, 16'h1234);
        chk8(O_ACC, 8'h5a);
        chk8(O_IDX_X, 8'ha5);
        chk8(O_IDX_Y, 8'h00);
        chk8(O_CC, 8'hf3);
        chk8({7'h00, O_IRQ_READY}, 8'h00);
        run_seq(SEQ_CALL, SRC_ACC, 16'h4000);
        chk16(O_SP, 16'h00c0);
        chk16(O_IP, 16'h4000);
        run_seq(SEQ_RET, SRC_ACC, 16'h0000);
        chk16(O_IP, 16'h1234);
        chk16(O_SP, 16'h00c2);
        // flags saved and restored
        run_seq(SEQ_PUSH1, SRC_CC, 16'h0000);
        chk16(O_SP, 16'h00c1);
        pulse_ops(4'b0100);
        chk8(O_CC, 8'hf2);
        run_seq(SEQ_POP1, SRC_CC, 16'h0000);
        chk8(O_CC, 8'hf3);
        // pop from the top wraps
        I_SP_REINIT = 1'b1;
        I_X_WE = 1'b1;
        tick();
        {I_SP_REINIT, I_X_WE} = 2'h0;
        chk16(O_SP, 16'h00ff);
        run_seq(SEQ_POP1, SRC_X, 16'h0000);
        chk16(O_SP, 16'h00c0);
        chk8(O_IDX_X, 8'ha5);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// file: include/crs_pkg.sv
// shared constants, types and sequence decoding of the cpu register set
`default_nettype none
package crs_pkg;
    // stack window: low bits variable, upper bits forced from the reset value
    localparam int CRS_SP_LOW_W = 6;
    localparam logic [15:0] CRS_SP_RESET = 16'h00ff;
    // condition flags: bits 7:5 always read one, unknown flags reset to zero
    localparam logic [7:0] CRS_CC_RESET = 8'he8;
    localparam logic [7:0] CRS_CC_FIXED = 8'he0;
    localparam int CRS_CC_H = 4;
    localparam int CRS_CC_I = 3;
    localparam int CRS_CC_N = 2;
    localparam int CRS_CC_Z = 1;
    localparam int CRS_CC_C = 0;
    // stack bytes used by each kind of sequence
    localparam logic [2:0] CRS_INT_BYTES = 3'h5;
    localparam logic [2:0] CRS_CALL_BYTES = 3'h2;
    localparam logic [2:0] CRS_ONE_BYTE = 3'h1;
    // reset values of the plain data registers
    localparam logic [7:0] CRS_DATA_RESET = 8'h00;
    localparam logic [15:0] CRS_IP_RESET = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PUSH = 2'b01,
        ST_POP = 2'b10
    } crs_state_e;

    typedef enum logic [2:0] {
        SEQ_INT = 3'b000,
        SEQ_CALL = 3'b001,
        SEQ_PUSH1 = 3'b010,
        SEQ_INTERRUPT_RETURN_OP = 3'b011,
        SEQ_RET = 3'b100,
        SEQ_POP1 = 3'b101
    } crs_seq_e;

    typedef enum logic [2:0] {
        SRC_ACC = 3'b000,
        SRC_X = 3'b001,
        SRC_Y = 3'b010,
        SRC_CC = 3'b011,
        SRC_PCL = 3'b100,
        SRC_PCH = 3'b101
    } crs_src_e;

    // alu outcome and which flags it is allowed to touch
    typedef struct packed {
        logic [7:0] res;
        logic carry;
        logic half;
        logic upd_h;
        logic upd_n;
        logic upd_z;
        logic upd_c;
    } crs_alu_s;

    // single-cycle flag instructions from the decoder
    typedef struct packed {
        logic set_carry_op;
        logic clear_carry_op;
        logic mask_op;
        logic unmask_op;
    } crs_ops_s;

    // stack memory port
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } crs_stk_s;

    // number of stack bytes moved by a sequence
    function automatic logic [2:0] crs_seq_len(input crs_seq_e k);
        case (k)
            SEQ_INT, SEQ_INTERRUPT_RETURN_OP: crs_seq_len = CRS_INT_BYTES;
            SEQ_CALL, SEQ_RET: crs_seq_len = CRS_CALL_BYTES;
            default: crs_seq_len = CRS_ONE_BYTE;
        endcase
    endfunction

    // register moved at a given step; pops run in reverse push order
    function automatic crs_src_e crs_seq_item(input crs_seq_e k,
            input logic [2:0] s, input crs_src_e one);
        case (k)
            SEQ_INT: begin
                case (s)
                    3'h0: crs_seq_item = SRC_PCL;
                    3'h1: crs_seq_item = SRC_PCH;
                    3'h2: crs_seq_item = SRC_X;
                    3'h3: crs_seq_item = SRC_ACC;
                    default: crs_seq_item = SRC_CC;
                endcase
            end
            SEQ_INTERRUPT_RETURN_OP: begin
                case (s)
                    3'h0: crs_seq_item = SRC_CC;
                    3'h1: crs_seq_item = SRC_ACC;
                    3'h2: crs_seq_item = SRC_X;
                    3'h3: crs_seq_item = SRC_PCH;
                    default: crs_seq_item = SRC_PCL;
                endcase
            end
            SEQ_CALL: crs_seq_item = (s == 3'h0) ? SRC_PCL : SRC_PCH;
            SEQ_RET: crs_seq_item = (s == 3'h0) ? SRC_PCH : SRC_PCL;
            default: crs_seq_item = one;
        endcase
    endfunction
endpackage
`default_nettype wire

// file: rtl/crs_cpu_regs.sv
// programmer-visible cpu registers with context stacking sequencer
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// (RULE1) 8-bit accumulator for alu data
// (RULE2) two 8-bit index registers
// (RULE3) second index never stacked on interrupts
// (RULE4) 16-bit instruction pointer of two bytes
// (RULE5) flags reset to 111x1xxx
// (RULE6) flags pushed and popped explicitly
// (RULE7) half carry from add and adc
// (RULE8) mask set on entry or instruction
// (RULE9) masked requests latched until unmasked
// (RULE10) interrupt return clears the mask
// (RULE11) unmasking in a routine serves pending requests
// (RULE12) negative flag copies result bit 7
// (RULE13) zero flag marks zero result
// (RULE14) carry from arithmetic, instructions, shifts
// (RULE15) pointer post-decrements on push, pre-increments on pop
// (RULE16) 64-byte stack, reset to 00ffh
// (RULE17) pointer wraps silently both ways
// (RULE18) pointer low byte loadable directly
// (RULE19) interrupt pushes low pointer byte first
// (RULE20) call uses two bytes, interrupt five
// (RULE21) entry stacks pointer, x, a, flags
// (RULE22) pointer held within 00c0h to 00ffh
module crs_cpu_regs (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic [7:0] I_DATA,
    input wire logic I_ACC_WE,
    input wire logic I_X_WE,
    input wire logic I_Y_WE,
    input wire logic I_SP_WE,
    input wire logic I_SP_REINIT,
    input wire logic I_IP_WE,
    input wire logic I_IP_INC,
    input wire logic [15:0] I_IP_D,
    input wire logic I_ALU_EN,
    input wire crs_pkg::crs_alu_s I_ALU,
    input wire crs_pkg::crs_ops_s I_OPS,
    input wire logic I_SEQ_GO,
    input wire crs_pkg::crs_seq_e I_SEQ_KIND,
    input wire crs_pkg::crs_src_e I_PP_SEL,
    input wire logic I_TRAP,
    input wire logic I_IRQ,
    input wire logic [7:0] I_STK_RDATA,
    output logic [7:0] O_ACC,
    output logic [7:0] O_IDX_X,
    output logic [7:0] O_IDX_Y,
    output logic [15:0] O_IP,
    output logic [7:0] O_CC,
    output logic [15:0] O_SP,
    output crs_pkg::crs_stk_s O_STK,
    output logic O_BUSY,
    output logic O_IRQ_READY
);
    import crs_pkg::*;

    // architectural registers
    logic [7:0] acc_reg;
    logic [7:0] acc_next;
    logic [7:0] x_reg;
    logic [7:0] x_next;
    logic [7:0] y_reg;
    logic [7:0] y_next;
    logic [15:0] ip_reg;
    logic [15:0] ip_next;

    // sequencer state
    crs_state_e state_reg;
    crs_state_e state_next;
    crs_seq_e kind_reg;
    crs_src_e one_reg;
    logic [2:0] step_reg;
    logic [2:0] step_next;
    logic [2:0] len_reg;
    logic [15:0] target_reg;
    logic cap_valid_reg;
    logic cap_valid_next;
    crs_src_e cap_src_reg;
    logic pend_reg;
    logic pend_next;
    logic irq_ready_reg;
    logic busy_reg;
    crs_stk_s stk_reg;
    crs_stk_s stk_next;

    // values from the submodules and the byte to be pushed
    logic [7:0] cc_val;
    logic [15:0] sp_val;
    logic [15:0] sp_up;
    logic [7:0] push_val;

    // idle decode and start conditions
    wire logic idle = (state_reg == ST_IDLE) & ~cap_valid_reg;
    wire logic start = idle & I_SEQ_GO;
    wire logic start_int = start & (I_SEQ_KIND == SEQ_INT);
    wire logic start_pop = (I_SEQ_KIND == SEQ_INTERRUPT_RETURN_OP) |
        (I_SEQ_KIND == SEQ_RET) | (I_SEQ_KIND == SEQ_POP1);
    wire logic last_step = (step_reg == len_reg - 3'h1);
    wire logic in_push = (state_reg == ST_PUSH);
    wire logic in_pop = (state_reg == ST_POP);
    wire crs_src_e cur_src = crs_seq_item(kind_reg, step_reg, one_reg);
    wire logic seq_jump = in_push & last_step &
        ((kind_reg == SEQ_INT) | (kind_reg == SEQ_CALL));

    // capture decode: popped byte lands one cycle after its read
    wire logic cap_acc = cap_valid_reg & (cap_src_reg == SRC_ACC);
    wire logic cap_x = cap_valid_reg & (cap_src_reg == SRC_X);
    wire logic cap_y = cap_valid_reg & (cap_src_reg == SRC_Y);
    wire logic cap_cc = cap_valid_reg & (cap_src_reg == SRC_CC);
    wire logic cap_pcl = cap_valid_reg & (cap_src_reg == SRC_PCL);
    wire logic cap_pch = cap_valid_reg & (cap_src_reg == SRC_PCH);
    wire logic cap_interrupt_return_op = cap_cc & (kind_reg == SEQ_INTERRUPT_RETURN_OP);

    // condition flag register; alu and instruction updates only between sequences
    crs_flags u_flags (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_alu(I_ALU),
        .i_alu_en(I_ALU_EN & idle),
        .i_ops(idle ? I_OPS : '0),
        .i_entry(start_int),
        .i_load(cap_cc),
        .i_load_interrupt_return_op(cap_interrupt_return_op),
        .i_load_data(I_STK_RDATA),
        .o_cc(cc_val)
    );

    // stack pointer: decrement after each push, increment before each pop
    crs_sp #(
        .STACK_BITS(CRS_SP_LOW_W)
    ) u_sp (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_dec(in_push), // see RULE15
        .i_inc(in_pop), // see RULE15
        .i_reinit(idle & I_SP_REINIT), // see RULE16
        .i_load(idle & I_SP_WE & ~I_SP_REINIT), // see RULE18
        .i_load_data(I_DATA),
        .o_sp(sp_val),
        .o_sp_up(sp_up)
    );

    // byte to be pushed in the current step
    always_comb begin
        case (cur_src)
            SRC_ACC: push_val = acc_reg;
            SRC_X: push_val = x_reg;
            SRC_Y: push_val = y_reg; // explicit push only, see RULE3
            SRC_CC: push_val = cc_val; // see RULE6
            SRC_PCL: push_val = ip_reg[7:0];
            default: push_val = ip_reg[15:8];
        endcase
    end

    // sequencer next state and stack port
    always_comb begin
        state_next = state_reg;
        step_next = step_reg;
        cap_valid_next = 1'b0;
        stk_next = '0;
        stk_next.addr = stk_reg.addr;
        case (state_reg)
            ST_IDLE: begin
                if (start) begin
                    state_next = start_pop ? ST_POP : ST_PUSH;
                    step_next = 3'h0;
                end
            end
            ST_PUSH: begin
                // write at the free location, pointer then moves down
                stk_next.addr = sp_val; // see RULE19
                stk_next.wdata = push_val;
                stk_next.we = 1'b1;
                step_next = step_reg + 3'h1;
                if (last_step) begin
                    state_next = ST_IDLE; // see RULE20
                end
            end
            ST_POP: begin
                // pointer moves up first, then the byte is read there
                stk_next.addr = sp_up;
                stk_next.re = 1'b1;
                cap_valid_next = 1'b1;
                step_next = step_reg + 3'h1;
                if (last_step) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // data register next values: popped bytes beat direct writes
    assign acc_next = cap_acc ? I_STK_RDATA :
        (idle & I_ACC_WE) ? I_DATA : acc_reg; // see RULE1
    assign x_next = cap_x ? I_STK_RDATA :
        (idle & I_X_WE) ? I_DATA : x_reg; // see RULE2
    assign y_next = cap_y ? I_STK_RDATA :
        (idle & I_Y_WE) ? I_DATA : y_reg; // see RULE2

    // instruction pointer: restore, vector or call target, write, step
    assign ip_next = cap_pch ? {I_STK_RDATA, ip_reg[7:0]} :
        cap_pcl ? {ip_reg[15:8], I_STK_RDATA} :
        seq_jump ? target_reg :
        (idle & I_IP_WE) ? I_IP_D :
        (idle & I_IP_INC) ? ip_reg + 16'h0001 : ip_reg; // see RULE4

    // pending request: a new request wins over the clear on entry
    assign pend_next = I_IRQ |
        (pend_reg & ~(start_int & ~I_TRAP)); // see RULE9

    // data registers
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            acc_reg <= CRS_DATA_RESET;
            x_reg <= CRS_DATA_RESET;
            y_reg <= CRS_DATA_RESET;
            ip_reg <= CRS_IP_RESET;
        end else begin
            acc_reg <= acc_next;
            x_reg <= x_next;
            y_reg <= y_next;
            ip_reg <= ip_next;
        end
    end

    // sequencer registers and start snapshot
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            state_reg <= ST_IDLE;
            kind_reg <= SEQ_PUSH1;
            one_reg <= SRC_ACC;
            step_reg <= 3'h0;
            len_reg <= CRS_ONE_BYTE;
            target_reg <= CRS_IP_RESET;
            cap_valid_reg <= 1'b0;
            cap_src_reg <= SRC_ACC;
            stk_reg <= '0;
        end else begin
            state_reg <= state_next;
            step_reg <= step_next;
            cap_valid_reg <= cap_valid_next;
            cap_src_reg <= cur_src;
            stk_reg <= stk_next;
            if (start) begin
                kind_reg <= I_SEQ_KIND;
                one_reg <= I_PP_SEL;
                len_reg <= crs_seq_len(I_SEQ_KIND); // see RULE20
                target_reg <= I_IP_D; // see RULE21
            end
        end
    end

    // pending latch and status outputs
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            pend_reg <= 1'b0;
            irq_ready_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            pend_reg <= pend_next;
            // served when unmasked and the sequencer is idle with no go, whatever routine is running
            irq_ready_reg <= pend_reg & ~cc_val[CRS_CC_I] & idle &
                ~I_SEQ_GO; // see RULE11
            busy_reg <= (state_next != ST_IDLE) | cap_valid_next;
        end
    end

    assign O_ACC = acc_reg;
    assign O_IDX_X = x_reg;
    assign O_IDX_Y = y_reg;
    assign O_IP = ip_reg;
    assign O_CC = cc_val;
    assign O_SP = sp_val;
    assign O_STK = stk_reg;
    assign O_BUSY = busy_reg;
    assign O_IRQ_READY = irq_ready_reg;
endmodule
`default_nettype wire

// file: rtl/crs_flags.sv
// condition flag register with alu, instruction and restore updates
`timescale 1ns/100ps
`default_nettype none
module crs_flags (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire crs_pkg::crs_alu_s i_alu,
    input wire logic i_alu_en,
    input wire crs_pkg::crs_ops_s i_ops,
    input wire logic i_entry,
    input wire logic i_load,
    input wire logic i_load_interrupt_return_op,
    input wire logic [7:0] i_load_data,
    output logic [7:0] o_cc
);
    import crs_pkg::*;

    logic [7:0] cc_reg;
    logic [7:0] cc_next;
    logic [7:0] cc_upd;
    logic [7:0] cc_ld;

    // per-flag next values from the alu and flag instructions
    wire logic upd_h = i_alu_en & i_alu.upd_h;
    wire logic upd_n = i_alu_en & i_alu.upd_n;
    wire logic upd_z = i_alu_en & i_alu.upd_z;
    wire logic upd_c = i_alu_en & i_alu.upd_c;
    wire logic h_next = upd_h ? i_alu.half : cc_reg[CRS_CC_H]; // see RULE7
    wire logic n_next = upd_n ? i_alu.res[7] : cc_reg[CRS_CC_N]; // see RULE12
    wire logic z_next = upd_z ? (i_alu.res == 8'h00) : cc_reg[CRS_CC_Z]; // see RULE13
    // set-carry beats clear-carry, both beat the alu
    wire logic c_next = i_ops.set_carry_op ? 1'b1 :
        i_ops.clear_carry_op ? 1'b0 :
        upd_c ? i_alu.carry : cc_reg[CRS_CC_C]; // see RULE14
    // mask on entry or instruction wins over unmask
    wire logic i_next = (i_entry | i_ops.mask_op) ? 1'b1 :
        i_ops.unmask_op ? 1'b0 : cc_reg[CRS_CC_I]; // see RULE8

    // assemble the updated and the restored byte
    always_comb begin
        cc_upd = CRS_CC_FIXED;
        cc_upd[CRS_CC_H] = h_next;
        cc_upd[CRS_CC_I] = i_next;
        cc_upd[CRS_CC_N] = n_next;
        cc_upd[CRS_CC_Z] = z_next;
        cc_upd[CRS_CC_C] = c_next;
        cc_ld = i_load_data | CRS_CC_FIXED; // see RULE6
        if (i_load_interrupt_return_op) begin
            cc_ld[CRS_CC_I] = 1'b0; // see RULE10
        end
        cc_next = i_load ? cc_ld : cc_upd;
    end

    // flag storage
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cc_reg <= CRS_CC_RESET; // see RULE5
        end else begin
            cc_reg <= cc_next;
        end
    end

    assign o_cc = cc_reg;
endmodule
`default_nettype wire

// file: rtl/crs_sp.sv
// stack pointer confined to a wrapping window below the reset value
`timescale 1ns/100ps
`default_nettype none
module crs_sp #(
    parameter int STACK_BITS = crs_pkg::CRS_SP_LOW_W
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_dec,
    input wire logic i_inc,
    input wire logic i_reinit,
    input wire logic i_load,
    input wire logic [7:0] i_load_data,
    output logic [15:0] o_sp,
    output logic [15:0] o_sp_up
);
    import crs_pkg::*;

    if (STACK_BITS < 1 || STACK_BITS > 8) begin : g_bad_width
        $error("crs_sp: STACK_BITS must lie in 1..8");
    end

    localparam logic [STACK_BITS-1:0] LOW_RESET =
        CRS_SP_RESET[STACK_BITS-1:0];

    logic [STACK_BITS-1:0] low_reg;
    logic [STACK_BITS-1:0] low_next;

    // only the low bits move; wrap is the natural modulo of their width
    wire logic [STACK_BITS-1:0] low_up = low_reg + STACK_BITS'(1); // see RULE17
    wire logic [STACK_BITS-1:0] low_dn = low_reg - STACK_BITS'(1); // see RULE17
    assign low_next = i_reinit ? LOW_RESET :
        i_load ? i_load_data[STACK_BITS-1:0] : // see RULE18
        i_dec ? low_dn : i_inc ? low_up : low_reg; // see RULE15

    // pointer storage
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            low_reg <= LOW_RESET; // see RULE16
        end else begin
            low_reg <= low_next;
        end
    end

    // upper bits forced to the window base
    assign o_sp = {CRS_SP_RESET[15:STACK_BITS], low_reg}; // see RULE22
    assign o_sp_up = {CRS_SP_RESET[15:STACK_BITS], low_up};
endmodule
`default_nettype wire
